// ### dqd_pkg.sv
// package: register map, descriptor layout, state and carrier types of the descriptor queue dma
package dqd_pkg;

  // ****************************************
  // channel counts
  // ****************************************
  localparam int NCH_DIR = 8;
  localparam int NCH     = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_HEAD     = 12'h000;
  localparam logic [11:0] OFS_CP       = 12'h040;
  localparam logic [11:0] OFS_TXEN_SET = 12'h080;
  localparam logic [11:0] OFS_TXEN_CLR = 12'h084;
  localparam logic [11:0] OFS_RXEN_SET = 12'h088;
  localparam logic [11:0] OFS_RXEN_CLR = 12'h08c;
  localparam logic [11:0] OFS_TXRAW    = 12'h090;
  localparam logic [11:0] OFS_RXRAW    = 12'h094;
  localparam logic [11:0] OFS_GEN      = 12'h098;

  // ****************************************
  // descriptor layout
  // ****************************************
  localparam logic [31:0] W0_OFS   = 32'h0000_0000;
  localparam logic [31:0] W1_OFS   = 32'h0000_0004;
  localparam logic [31:0] W2_OFS   = 32'h0000_0008;
  localparam logic [31:0] W3_OFS   = 32'h0000_000c;
  localparam int FL_FIRST = 31;
  localparam int FL_LAST  = 30;
  localparam int FL_OWN   = 29;
  localparam int FL_QEND  = 28;
  localparam int FL_TDOWN = 27;
  localparam int FL_PCSUM = 26;
  localparam int BOFS_LSB = 16;
  localparam int LEN_MSB  = 15;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RD3   = 3'h1,
    ST_RD0   = 3'h3,
    ST_WRSOP = 3'h2,
    ST_WREOP = 3'h6
  } dqd_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dqd_apb_req_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dqd_mreq_t;

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
  } dqd_mrsp_t;

  typedef struct packed {
    logic [NCH-1:0][31:0] head;
    logic [NCH-1:0][31:0] last;
    logic [NCH-1:0][31:0] cpw;
    logic [NCH-1:0]       active;
    logic [7:0]           txm;
    logic [7:0]           rxm;
    logic                 gen;
    dqd_state_t           state;
    logic [3:0]           ch;
    logic [31:0]          cur;
    logic [31:0]          sop;
    logic [31:0]          sopf;
    logic [31:0]          flags;
    logic [31:0]          next;
    dqd_mreq_t            mreq;
    logic [31:0]          prdata;
    logic                 perr;
  } dqd_regs_t;

endpackage

// ### dqd_descriptor_queue_dma.sv
// module: descriptor queue dma with apb registers and a word memory master port
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] eight tx and eight rx head pointers
// [RQ2] software zeroes all heads before enabling
// [RQ3] device_owns_flag flag set means device owns packet
// [RQ4] head write starts idle queue there
// [RQ5] zero next pointer ends the queue
// [RQ6] software never rewrites an active head
// [RQ7] appended lists already end in zero
// [RQ8] set queue end flag on last descriptor
// [RQ9] software restarts channel after queue end
// [RQ10] same procedure for tx and rx
// [RQ11] clear device_owns_flag on first descriptor after packet
// [RQ12] eight tx and eight rx completion pointers
// [RQ13] completion read returns last processed descriptor
// [RQ14] interrupt active while pointers differ
// [RQ15] equal completion write acknowledges interrupt
// [RQ16] interrupt needs channel mask and global enable
// [RQ17] raw status ignores the masks
// [RQ18] descriptor is four aligned words
// [RQ19] words hold next, buffer, offset, length
// [RQ20] word three holds flags and packet length
// [RQ21] halt channel at queue end
// [RQ22] never change pointers or length fields
// [RQ23] follow a link patched in time
// [RQ24] nonzero head write activates and fetches
module dqd_descriptor_queue_dma (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire dqd_pkg::dqd_apb_req_t apb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  output dqd_pkg::dqd_mreq_t      mreq,
  input  wire dqd_pkg::dqd_mrsp_t mrsp,
  output logic                    irq
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= dqd_pkg::OFS_GEN);
  endfunction

  function automatic logic [3:0] reg_ch(input logic [11:0] a);
    reg_ch = a[5:2];
  endfunction

  // round robin search, returns found flag and channel
  function automatic logic [4:0] pick(input logic [15:0] act, input logic [3:0] prev);
    logic [3:0] c;
    pick = 5'h00;
    c = 4'h0;
    for (int i = 16; i >= 1; i--)
    begin
      c = prev + 4'(i);
      if (act[c])
        pick = {1'b1, c};
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  dqd_pkg::dqd_regs_t st_reg;
  dqd_pkg::dqd_regs_t st_next;
  logic [15:0]        raw;
  logic [4:0]         sel;
  logic [3:0]         wch;
  logic               acc_wr;

  for (genvar g = 0; g < dqd_pkg::NCH; g++)
  begin : g_raw
    assign raw[g] = st_reg.last[g] != st_reg.cpw[g]; // [RQ14] [RQ17]
  end

  assign sel    = pick(st_reg.active, st_reg.ch);
  assign wch    = reg_ch(apb.paddr);
  assign acc_wr = apb.psel & apb.penable & apb.pwrite;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    // descriptor engine, one channel at a time
    case (st_reg.state)
      dqd_pkg::ST_IDLE:
      begin
        if (sel[4])
        begin
          st_next.ch         = sel[3:0];
          st_next.cur        = st_reg.head[sel[3:0]]; // [RQ4] [RQ24]
          st_next.mreq.valid = 1'b1;
          st_next.mreq.we    = 1'b0;
          st_next.mreq.addr  = st_reg.head[sel[3:0]] + dqd_pkg::W3_OFS; // [RQ18]
          st_next.state      = dqd_pkg::ST_RD3;
        end
      end
      dqd_pkg::ST_RD3:
      begin
        if (mrsp.ready)
        begin
          st_next.flags = mrsp.rdata;
          if (mrsp.rdata[dqd_pkg::FL_FIRST] && !mrsp.rdata[dqd_pkg::FL_OWN])
          begin
            // packet not handed over: stop the channel
            st_next.active[st_reg.ch] = 1'b0; // [RQ3]
            st_next.mreq.valid        = 1'b0;
            st_next.state             = dqd_pkg::ST_IDLE;
          end
          else
          begin
            if (mrsp.rdata[dqd_pkg::FL_FIRST])
            begin
              st_next.sop  = st_reg.cur; // [RQ11]
              st_next.sopf = mrsp.rdata;
            end
            // next pointer read late so a patched link is seen
            st_next.mreq.addr = st_reg.cur + dqd_pkg::W0_OFS; // [RQ23] [RQ19]
            st_next.state     = dqd_pkg::ST_RD0;
          end
        end
      end
      dqd_pkg::ST_RD0:
      begin
        if (mrsp.ready)
        begin
          st_next.next = mrsp.rdata;
          if (!st_reg.flags[dqd_pkg::FL_LAST])
          begin
            st_next.head[st_reg.ch]   = mrsp.rdata; // [RQ23]
            st_next.active[st_reg.ch] = mrsp.rdata != 32'h0000_0000; // [RQ5]
            st_next.mreq.valid        = 1'b0;
            st_next.state             = dqd_pkg::ST_IDLE;
          end
          else if (st_reg.sop == st_reg.cur)
          begin
            st_next.mreq.we                    = 1'b1;
            st_next.mreq.addr                  = st_reg.cur + dqd_pkg::W3_OFS;
            st_next.mreq.wdata                 = st_reg.flags; // [RQ22] [RQ20]
            st_next.mreq.wdata[dqd_pkg::FL_OWN]  = 1'b0; // [RQ11]
            st_next.mreq.wdata[dqd_pkg::FL_QEND] = mrsp.rdata == 32'h0000_0000; // [RQ8]
            st_next.state                      = dqd_pkg::ST_WREOP;
          end
          else
          begin
            st_next.mreq.we                   = 1'b1;
            st_next.mreq.addr                 = st_reg.sop + dqd_pkg::W3_OFS;
            st_next.mreq.wdata                = st_reg.sopf; // [RQ22]
            st_next.mreq.wdata[dqd_pkg::FL_OWN] = 1'b0; // [RQ11]
            st_next.state                     = dqd_pkg::ST_WRSOP;
          end
        end
      end
      dqd_pkg::ST_WRSOP:
      begin
        if (mrsp.ready)
        begin
          st_next.mreq.addr                    = st_reg.cur + dqd_pkg::W3_OFS;
          st_next.mreq.wdata                   = st_reg.flags; // [RQ22]
          st_next.mreq.wdata[dqd_pkg::FL_QEND] = st_reg.next == 32'h0000_0000; // [RQ8]
          st_next.state                        = dqd_pkg::ST_WREOP;
        end
      end
      dqd_pkg::ST_WREOP:
      begin
        if (mrsp.ready)
        begin
          st_next.last[st_reg.ch]   = st_reg.cur; // [RQ13]
          st_next.head[st_reg.ch]   = st_reg.next;
          st_next.active[st_reg.ch] = st_reg.next != 32'h0000_0000; // [RQ21] [RQ5]
          st_next.mreq.valid        = 1'b0;
          st_next.mreq.we           = 1'b0;
          st_next.state             = dqd_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_next.mreq.valid = 1'b0;
        st_next.state      = dqd_pkg::ST_IDLE;
      end
    endcase

    // apb read data captured in the setup cycle
    if (apb.psel && !apb.penable)
    begin
      st_next.perr   = !mapped(apb.paddr);
      st_next.prdata = 32'h0000_0000;
      if (apb.paddr < dqd_pkg::OFS_CP)
        st_next.prdata = st_reg.head[wch]; // [RQ1] [RQ10]
      else if (apb.paddr < dqd_pkg::OFS_TXEN_SET)
        st_next.prdata = st_reg.last[wch]; // [RQ12] [RQ13]
      else if (apb.paddr == dqd_pkg::OFS_TXEN_SET)
        st_next.prdata = {24'h000000, st_reg.txm};
      else if (apb.paddr == dqd_pkg::OFS_RXEN_SET)
        st_next.prdata = {24'h000000, st_reg.rxm};
      else if (apb.paddr == dqd_pkg::OFS_TXRAW)
        st_next.prdata = {24'h000000, raw[7:0]}; // [RQ17]
      else if (apb.paddr == dqd_pkg::OFS_RXRAW)
        st_next.prdata = {24'h000000, raw[15:8]}; // [RQ17]
      else if (apb.paddr == dqd_pkg::OFS_GEN)
        st_next.prdata = {31'h0, st_reg.gen};
    end

    // apb writes take effect in the access cycle
    if (acc_wr && mapped(apb.paddr))
    begin
      if (apb.paddr < dqd_pkg::OFS_CP)
      begin
        // an active head is left alone
        if (!st_reg.active[wch])
        begin
          st_next.head[wch]   = apb.pwdata; // [RQ4] [RQ24]
          st_next.active[wch] = apb.pwdata != 32'h0000_0000; // [RQ24]
        end
      end
      else if (apb.paddr < dqd_pkg::OFS_TXEN_SET)
        st_next.cpw[wch] = apb.pwdata; // [RQ15]
      else if (apb.paddr == dqd_pkg::OFS_TXEN_SET)
        st_next.txm = st_reg.txm | apb.pwdata[7:0];
      else if (apb.paddr == dqd_pkg::OFS_TXEN_CLR)
        st_next.txm = st_reg.txm & ~apb.pwdata[7:0];
      else if (apb.paddr == dqd_pkg::OFS_RXEN_SET)
        st_next.rxm = st_reg.rxm | apb.pwdata[7:0];
      else if (apb.paddr == dqd_pkg::OFS_RXEN_CLR)
        st_next.rxm = st_reg.rxm & ~apb.pwdata[7:0];
      else if (apb.paddr == dqd_pkg::OFS_GEN)
        st_next.gen = apb.pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready  = 1'b1;
  assign prdata  = st_reg.prdata;
  assign pslverr = apb.psel & apb.penable & st_reg.perr;
  assign mreq    = st_reg.mreq;
  assign irq     = st_reg.gen & (|(raw & {st_reg.rxm, st_reg.txm})); // [RQ16]

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_gate_en: assert property (irq |-> st_reg.gen && ((st_reg.txm | st_reg.rxm) != 8'h00)) // [RQ16]
    else $error("irq without enables");

  a_ack_clears_raw: assert property (acc_wr && apb.paddr >= dqd_pkg::OFS_CP && apb.paddr < dqd_pkg::OFS_TXEN_SET
    && apb.paddr[1:0] == 2'h0 && apb.pwdata == st_reg.last[wch] && st_reg.state != dqd_pkg::ST_WREOP
    |=> !raw[$past(wch)]) // [RQ15]
    else $error("matching ack left raw set");

  a_eoq_on_zero: assert property (st_reg.state == dqd_pkg::ST_WREOP && mreq.valid
    |-> mreq.wdata[dqd_pkg::FL_QEND] == (st_reg.next == 32'h0000_0000)) // [RQ8]
    else $error("queue end flag wrong");

  a_device_owns_flag_cleared: assert property (st_reg.state == dqd_pkg::ST_WRSOP
    |-> !mreq.wdata[dqd_pkg::FL_OWN] && mreq.addr == st_reg.sop + dqd_pkg::W3_OFS) // [RQ11]
    else $error("device_owns_flag not cleared on first descriptor");

  a_halt_at_end: assert property (st_reg.state == dqd_pkg::ST_WREOP && mrsp.ready && st_reg.next == 32'h0000_0000
    |=> !st_reg.active[$past(st_reg.ch)] && st_reg.state == dqd_pkg::ST_IDLE) // [RQ21]
    else $error("channel not halted at queue end");

  a_follow_link: assert property (st_reg.state == dqd_pkg::ST_WREOP && mrsp.ready && st_reg.next != 32'h0000_0000
    |=> st_reg.active[$past(st_reg.ch)] && st_reg.head[$past(st_reg.ch)] == $past(st_reg.next)) // [RQ23]
    else $error("patched link not followed");

  a_head_starts: assert property (acc_wr && apb.paddr < dqd_pkg::OFS_CP && apb.paddr[1:0] == 2'h0
    && !st_reg.active[wch] && apb.pwdata != 32'h0000_0000
    |=> st_reg.active[$past(wch)] && st_reg.head[$past(wch)] == $past(apb.pwdata)) // [RQ24]
    else $error("head write did not start channel");

  a_write_word3: assert property (mreq.valid && mreq.we
    |-> mreq.addr == st_reg.cur + dqd_pkg::W3_OFS || mreq.addr == st_reg.sop + dqd_pkg::W3_OFS) // [RQ22]
    else $error("write outside flag word");

  a_keep_length: assert property (st_reg.state == dqd_pkg::ST_WREOP && mreq.valid
    |-> mreq.wdata[dqd_pkg::LEN_MSB:0] == st_reg.flags[dqd_pkg::LEN_MSB:0]) // [RQ22]
    else $error("packet length altered");

  a_raw_matches: assert property (st_reg.state == dqd_pkg::ST_WREOP && mrsp.ready
    |=> raw[$past(st_reg.ch)] == (st_reg.cpw[$past(st_reg.ch)] != $past(st_reg.cur))) // [RQ14]
    else $error("raw status stuck");

  a_fetch_head: assert property (st_reg.state == dqd_pkg::ST_IDLE && sel[4]
    |=> mreq.valid && !mreq.we && mreq.addr == st_reg.cur + dqd_pkg::W3_OFS) // [RQ4]
    else $error("fetch not issued");

endmodule

`default_nettype wire

// ### dqd_mem_model.sv
// partner: word memory holding descriptors, answering promptly or with random stalls
`timescale 1ns/1ps
`default_nettype none
module dqd_mem_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               slow,
  input  wire dqd_pkg::dqd_mreq_t mreq,
  output var  dqd_pkg::dqd_mrsp_t mrsp
);
  logic [31:0] mem [0:255];
  logic [31:0] last_rd;
  logic        go;
  int          n_acc;

  // ****************************************
  // one aligned word per request
  // ****************************************
  always_comb
  begin
    mrsp.ready = mreq.valid & go;
    mrsp.rdata = mrsp.ready ? mem[mreq.addr[9:2]] : ~last_rd;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go      <= 1'b1;
      n_acc   <= 0;
      last_rd <= 32'h0;
    end
    else
    begin
      go <= slow ? ($urandom_range(3) == 0) : 1'b1;
      if (mrsp.ready)
      begin
        n_acc   <= n_acc + 1;
        last_rd <= mrsp.rdata;
        if (mreq.we)
          mem[mreq.addr[9:2]] <= mreq.wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### dqd_descriptor_queue_dma_bench.sv
// testbench: descriptor queue dma against a reference walk of the lists
`timescale 1ns/1ps
`default_nettype none
module dqd_descriptor_queue_dma_bench;
  localparam logic [31:0] F_SOP = 32'h8000_0000;
  localparam logic [31:0] F_EOP = 32'h4000_0000;
  localparam logic [31:0] F_OWN = 32'h2000_0000;
  logic                  pclk;
  logic                  presetn;
  logic                  slow;
  dqd_pkg::dqd_apb_req_t apb;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  dqd_pkg::dqd_mreq_t    mreq;
  dqd_pkg::dqd_mrsp_t    mrsp;
  logic                  irq;
  logic [31:0]           em [0:255];
  int                    n_mismatch = 0;
  int                    tests_run = 0;

  dqd_descriptor_queue_dma u_dqd_descriptor_queue_dma (.pclk(pclk), .presetn(presetn), .apb(apb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .mreq(mreq), .mrsp(mrsp), .irq(irq));
  dqd_mem_model u_dqd_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow), .mreq(mreq), .mrsp(mrsp));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // checks, bus cycles, reference model
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int i;
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    apb <= '0;
    if (i >= 50)
    begin
      chk(0, 1, "apb timeout");
      print_verdict;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        er;
    xfer(1'b1, a, d, x, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic        er;
    xfer(1'b0, a, 32'h0, d, er);
    chk(d, e, m);
  endtask

  task automatic irq_is(input logic e, input string m);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e}, m);
  endtask

  function automatic logic [11:0] ra(input logic [11:0] b, input int c);
    return b + 12'(4 * c);
  endfunction

  function automatic logic [31:0] da(input int k);
    return 32'h40 + 32'(16 * k);
  endfunction

  function automatic void put(input int k, input int nk, input logic [31:0] fl);
    logic [31:0] w [4];
    w[0] = (nk < 0) ? 32'h0 : da(nk);
    w[1] = $urandom;
    w[2] = $urandom;
    w[3] = fl | 32'($urandom_range(16'hffff));
    for (int j = 0; j < 4; j++)
    begin
      em[16 + 4 * k + j] = w[j];
      u_dqd_mem_model.mem[16 + 4 * k + j] = w[j];
    end
  endfunction

  function automatic void link(input logic [31:0] p, input logic [31:0] t);
    em[p[9:2]] = t;
    u_dqd_mem_model.mem[p[9:2]] = t;
  endfunction

  // reference walk: expected memory, completion, head and access count
  function automatic void walk(input logic [31:0] a, inout logic [31:0] cp, output logic [31:0] hd,
                               output int acc);
    logic [31:0] f, n, s;
    acc = 0;
    s = 0;
    hd = a;
    while (hd != 0)
    begin
      f = em[hd[9:2] + 3];
      acc++;
      if (f[dqd_pkg::FL_FIRST] && !f[dqd_pkg::FL_OWN])
        return;
      n = em[hd[9:2]];
      acc++;
      if (f[dqd_pkg::FL_FIRST])
        s = hd;
      if (f[dqd_pkg::FL_LAST])
      begin
        if (s != hd)
        begin
          em[s[9:2] + 3][dqd_pkg::FL_OWN] = 1'b0;
          acc++;
        end
        else
          f[dqd_pkg::FL_OWN] = 1'b0;
        f[dqd_pkg::FL_QEND] = (n == 0);
        em[hd[9:2] + 3] = f;
        acc++;
        cp = hd;
      end
      hd = n;
    end
  endfunction

  task automatic settle(input int n);
    int i;
    i = 0;
    while (u_dqd_mem_model.n_acc < n && i < 3000)
    begin
      @(posedge pclk);
      i++;
    end
    repeat (4) @(posedge pclk);
    chk(32'(u_dqd_mem_model.n_acc), 32'(n), "memory access count");
    if (i >= 3000)
      print_verdict;
  endtask

  task automatic mem_chk;
    int bad;
    bad = 0;
    for (int i = 0; i < 256; i++)
      if (u_dqd_mem_model.mem[i] !== em[i])
        bad++;
    chk(32'(bad), 32'h0, "descriptor memory");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] rd, cp, hd, bm;
    logic [11:0] en, raw;
    logic        er;
    int          acc, base, ch, kb;
    apb = '0;
    presetn = 1'b0;
    slow = 1'b0;
    void'($urandom(89));
    for (int i = 0; i < 256; i++)
    begin
      em[i] = 32'h0;
      u_dqd_mem_model.mem[i] = 32'h0;
    end
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(dqd_pkg::OFS_TXRAW, 32'h0, "tx raw reset");
    rdc(dqd_pkg::OFS_RXEN_SET, 32'h0, "rx enable reset");
    irq_is(1'b0, "irq reset");
    xfer(1'b0, 12'h09c, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    xfer(1'b1, 12'h002, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "misaligned error");
    for (int c = 0; c < 16; c++)
      wr(ra(dqd_pkg::OFS_HEAD, c), 32'h0);
    for (int c = 0; c < 16; c++)
      rdc(ra(dqd_pkg::OFS_HEAD, c), 32'h0, "head idle");
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      ch = 8 * i + $urandom_range(7);
      kb = 8 * i;
      en = (i == 0) ? dqd_pkg::OFS_TXEN_SET : dqd_pkg::OFS_RXEN_SET;
      raw = (i == 0) ? dqd_pkg::OFS_TXRAW : dqd_pkg::OFS_RXRAW;
      bm = 32'h1 << (ch % 8);
      slow <= (i == 1) | 1'($urandom_range(1));
      put(kb, kb + 1, F_SOP | F_EOP | F_OWN);
      put(kb + 1, kb + 2, F_SOP | F_OWN);
      put(kb + 2, kb + 3, 32'h0);
      put(kb + 3, -1, F_EOP);
      put(kb + 4, -1, F_SOP | F_EOP | F_OWN);
      base = u_dqd_mem_model.n_acc;
      cp = 32'h0;
      wr(ra(dqd_pkg::OFS_HEAD, ch), da(kb));
      if (i == 1)
        link(da(kb + 3), da(kb + 4));
      walk(da(kb), cp, hd, acc);
      settle(base + acc);
      mem_chk();
      rdc(ra(dqd_pkg::OFS_HEAD, ch), hd, "head at end");
      rdc(ra(dqd_pkg::OFS_CP, ch), cp, "completion read");
      rdc(raw, bm, "raw status");
      irq_is(1'b0, "irq unmasked off");
      wr(en, bm);
      irq_is(1'b0, "irq global off");
      wr(dqd_pkg::OFS_GEN, 32'h1);
      irq_is(1'b1, "irq enabled");
      wr(ra(dqd_pkg::OFS_CP, ch), cp ^ 32'h10);
      irq_is(1'b1, "irq after wrong ack");
      wr(ra(dqd_pkg::OFS_CP, ch), cp);
      irq_is(1'b0, "irq after ack");
      rdc(raw, 32'h0, "raw after ack");
      wr(dqd_pkg::OFS_GEN, 32'h0);
      wr(en + 12'h4, bm);
      rdc(en, 32'h0, "enable cleared");
      put(kb + 5, -1, F_SOP | F_EOP | F_OWN);
      link(cp, da(kb + 5));
      base = u_dqd_mem_model.n_acc;
      repeat (20) @(posedge pclk);
      chk(32'(u_dqd_mem_model.n_acc), 32'(base), "halted at queue end");
      wr(ra(dqd_pkg::OFS_HEAD, ch), da(kb + 5));
      walk(da(kb + 5), cp, hd, acc);
      settle(base + acc);
      mem_chk();
      rdc(ra(dqd_pkg::OFS_CP, ch), cp, "completion after restart");
      $display("test channel %0d done", ch);
    end
    ch = $urandom_range(7);
    put(20, -1, F_SOP | F_EOP);
    base = u_dqd_mem_model.n_acc;
    wr(ra(dqd_pkg::OFS_HEAD, ch), da(20));
    walk(da(20), cp, hd, acc);
    settle(base + acc);
    mem_chk();
    rdc(ra(dqd_pkg::OFS_HEAD, ch), hd, "head held on unowned packet");
    base = u_dqd_mem_model.n_acc;
    wr(ra(dqd_pkg::OFS_HEAD, ch), da(21));
    walk(da(21), cp, hd, acc);
    settle(base + acc);
    rdc(ra(dqd_pkg::OFS_HEAD, ch), hd, "head after empty descriptor");
    $display("test ownership done");
    print_verdict;
  end
endmodule
`default_nettype wire
